// *** shared/scs_defines.svh ***
// offsets, field positions, reset values and timing counts of the clock selector
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_CLK_HZ        10000000
// register offsets
`define SCS_A_CTRL        8'h00
`define SCS_A_PITCH       8'h04
`define SCS_A_PSTEP       8'h08
`define SCS_A_STATUS      8'h0C
`define SCS_A_INT_STAT    8'h10
`define SCS_A_INT_MASK    8'h14
`define SCS_A_TUNE        8'h18
`define SCS_A_EXT_CNT     8'h1C
// control field positions and reset value
`define SCS_CTRL_FIXED    0
`define SCS_CTRL_PREF_LO  1
`define SCS_CTRL_RATE_LO  4
`define SCS_CTRL_RST      32'h0000_0020
// pitch step command bits
`define SCS_PS_FINE_UP    0
`define SCS_PS_FINE_DN    1
`define SCS_PS_CRS_UP     2
`define SCS_PS_CRS_DN     3
`define SCS_PS_RESET      4
`define SCS_PS_PU_SMALL   5
`define SCS_PS_PD_SMALL   6
`define SCS_PS_PU_LARGE   7
`define SCS_PS_PD_LARGE   8
// status field positions
`define SCS_ST_SRC_LO     8
`define SCS_ST_MASTER     10
`define SCS_ST_CHAN_LO    16
`define SCS_ST_RATE_LO    28
// interrupt bits
`define SCS_IRQ_SRC_CHG   0
`define SCS_IRQ_REF_LOST  1
`define SCS_IRQ_IN_LO     2
// pitch steps in hertz and window divisors
`define SCS_FINE_HZ       16'sh0001
`define SCS_COARSE_HZ     16'sh0032
`define SCS_LIM_DIV       20
`define SCS_PULL_S_DIV    1000
`define SCS_PULL_L_DIV    25
// nominal rates in hertz
`define SCS_RATE_0        18'h07D00
`define SCS_RATE_1        18'h0AC44
`define SCS_RATE_2        18'h0BB80
`define SCS_RATE_3        18'h15888
`define SCS_RATE_4        18'h17700
`define SCS_RATE_5        18'h2B110
`define SCS_RATE_6        18'h2EE00
`define SCS_RATE_DOUBLE   18'h15888
`define SCS_RATE_QUAD     18'h2B110
// madi channel counts per speed range
`define SCS_CH_SINGLE     7'h40
`define SCS_CH_DOUBLE     7'h20
`define SCS_CH_QUAD       7'h10
// tuning word scale: round(2^40 / clock rate)
`define SCS_TW_MUL        22'h01AD7F
// detection window and valid edge band
`define SCS_WIN_CYC       8'hFF
`define SCS_CNT_MIN       10'h002
`define SCS_CNT_MAX       10'h3E8
`define SCS_SYNC_TOL      10'h001

`endif

// *** shared/scs_pkg.sv ***
// types of the sample clock source selector
package scs_pkg;

  typedef enum logic [1:0] {
    SCS_ST_FIXED  = 2'b00,
    SCS_ST_MASTER = 2'b01,
    SCS_ST_SLAVE  = 2'b10
  } scs_state_t;

  typedef enum logic [1:0] {
    SCS_LK_NONE = 2'b00,
    SCS_LK_LOCK = 2'b01,
    SCS_LK_SYNC = 2'b10
  } scs_lock_t;

endpackage

// *** src/scs_edge_meter.sv ***
// reference input synchroniser, edge counter and validity check
`timescale 1ns/1ps
`default_nettype none

module scs_edge_meter
#(
  parameter int CW = 10
)
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          pin,
  input  wire logic          win_end,
  input  wire logic [CW-1:0] cnt_min,
  input  wire logic [CW-1:0] cnt_max,
  output logic      [CW-1:0] count_q,
  output logic               valid_q
);

  logic          s1_q, s2_q, s3_q;
  logic [CW-1:0] acc_q, acc_d, count_d;
  logic          valid_d;
  logic [CW-1:0] total;

  always_comb
  begin
    total   = acc_q + CW'(s2_q & ~s3_q);
    acc_d   = win_end ? '0 : total;
    count_d = win_end ? total : count_q;
    valid_d = win_end ? (total >= cnt_min && total <= cnt_max) : valid_q;
  end

  // s1 feeds only s2: the pin is asynchronous to clk
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      acc_q   <= '0;
      count_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      acc_q   <= acc_d;
      count_q <= count_d;
      valid_q <= valid_d;
    end
  end

endmodule // scs_edge_meter

`default_nettype wire

// *** src/scs_selector.sv ***
// sample clock source selector with internal pitch synthesizer
//
// Functional notes
// - stay on the preferred input while it carries a valid signal.
// - preferred input invalid: scan remaining inputs in turn, lock to valid one.
// - no valid input anywhere: switch to master on the internal clock.
// - automatic mode, reference lost: fall back to internal clock as master (here only when no other input is valid).
// - report none, lock or sync for each of the four inputs.
// - fine pitch steps of 1 Hz, limited to plus or minus 5 percent.
// - presets for pull up and pull down of 0.1 and 4 percent.
// - coarse pitch steps of 50 Hz.
// - pitch offset applies only in master mode, only to this card.
// - in slave mode the external rate beats the host requested rate.
// - at quad speed only sixteen channels per madi port.
// - fixed internal mode ignores inputs and runs from internal clock.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"

module scs_selector
  import scs_pkg::*;
#(
  parameter int NIN = 4,
  parameter int CW  = 10
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  ref_pin,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_q,
  output logic             irq_q,
  output logic             master_q,
  output logic      [1:0]  cur_src_q,
  output logic      [31:0] tune_word_q,
  output logic             int_clk_q,
  output logic      [6:0]  madi_chans_q
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and measurement window

  logic rst_s1_q, rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  logic [7:0] win_q, win_d;
  logic       win_end;

  always_comb
  begin
    win_end = (win_q == `SCS_WIN_CYC);
    win_d   = win_end ? 8'h00 : win_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per input detection

  logic [CW-1:0] in_cnt [NIN];
  logic [NIN-1:0] in_valid;

  genvar g;
  generate
    for (g = 0; g < NIN; g++)
    begin : g_in
      scs_edge_meter #(.CW(CW)) u_meter (
        .clk     (ref_clk),
        .rst_n   (rst_sync_n),
        .pin     (ref_pin[g]),
        .win_end (win_end),
        .cnt_min (`SCS_CNT_MIN),
        .cnt_max (`SCS_CNT_MAX),
        .count_q (in_cnt[g]),
        .valid_q (in_valid[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register file state

  logic        fixed_q, fixed_d;
  logic [1:0]  pref_q, pref_d;
  logic [2:0]  rate_req_q, rate_req_d;
  logic [2:0]  rate_act_q, rate_act_d;
  logic signed [15:0] pitch_q, pitch_d;
  logic [5:0]  int_stat_q, int_stat_d;
  logic [5:0]  int_mask_q, int_mask_d;
  logic [31:0] rdata_d;
  scs_state_t  state_q, state_d;
  logic [1:0]  cur_q, cur_d;
  logic [7:0]  lock_q, lock_d;
  logic [CW-1:0] int_cnt_q, int_cnt_d, int_cnt_lat_q, int_cnt_lat_d;
  logic [31:0] acc_q, acc_d, tw_d;
  logic        msb_q;
  logic [6:0]  chans_d;
  logic        irq_d;

  logic        wr_ctrl, wr_pitch, wr_step;
  logic [17:0] nominal, freq;
  logic signed [15:0] lim, step, pull_s, pull_l;
  logic signed [17:0] tgt;
  logic [39:0] prod;
  logic [5:0]  ev;
  logic [3:0]  ev_in;

  ////////////////////////////////////////////////////////////////////////////
  // nominal rate, pitch and synthesizer

  always_comb
  begin
    case (rate_act_q)
      3'h0:    nominal = `SCS_RATE_0;
      3'h1:    nominal = `SCS_RATE_1;
      3'h2:    nominal = `SCS_RATE_2;
      3'h3:    nominal = `SCS_RATE_3;
      3'h4:    nominal = `SCS_RATE_4;
      3'h5:    nominal = `SCS_RATE_5;
      default: nominal = `SCS_RATE_6;
    endcase
    lim    = 16'(nominal / `SCS_LIM_DIV);
    pull_s = 16'(nominal / `SCS_PULL_S_DIV);
    pull_l = 16'(nominal / `SCS_PULL_L_DIV);
    wr_ctrl  = reg_wr && reg_addr == `SCS_A_CTRL;
    wr_pitch = reg_wr && reg_addr == `SCS_A_PITCH;
    wr_step  = reg_wr && reg_addr == `SCS_A_PSTEP;

    step = 16'sh0000;
    if (reg_wdata[`SCS_PS_FINE_UP])
      step = `SCS_FINE_HZ;
    else if (reg_wdata[`SCS_PS_FINE_DN])
      step = -`SCS_FINE_HZ;
    else if (reg_wdata[`SCS_PS_CRS_UP])
      step = `SCS_COARSE_HZ;
    else if (reg_wdata[`SCS_PS_CRS_DN])
      step = -`SCS_COARSE_HZ;

    tgt = 18'(pitch_q);
    if (wr_pitch)
      tgt = 18'(signed'(reg_wdata[15:0]));
    else if (wr_step)
    begin
      if (reg_wdata[`SCS_PS_RESET])
        tgt = 18'sh00000;
      else if (reg_wdata[`SCS_PS_PU_SMALL])
        tgt = 18'(pull_s);
      else if (reg_wdata[`SCS_PS_PD_SMALL])
        tgt = -18'(pull_s);
      else if (reg_wdata[`SCS_PS_PU_LARGE])
        tgt = 18'(pull_l);
      else if (reg_wdata[`SCS_PS_PD_LARGE])
        tgt = -18'(pull_l);
      else
        tgt = 18'(pitch_q) + 18'(step);
    end
    // clamp to five percent window, also after a rate change
    if (tgt > 18'(lim))
      pitch_d = lim;
    else if (tgt < -18'(lim))
      pitch_d = -lim;
    else
      pitch_d = 16'(tgt);

    // offset only reaches the synthesizer in master mode
    freq = (state_q == SCS_ST_SLAVE) ? nominal
                                     : 18'(nominal + 18'(pitch_q));
    // tuning word from nominal plus offset
    prod  = 40'(freq) * 40'(`SCS_TW_MUL);
    tw_d  = prod[39:8];
    acc_d = acc_q + tune_word_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection

  logic [1:0] pick, idx;
  logic       found;

  always_comb
  begin
    pick  = pref_q;
    found = 1'b0;
    idx   = pref_q;
    // scan in turn starting at the preferred input
    for (int i = 0; i < NIN; i++)
    begin
      idx = pref_q + 2'(i);
      if (!found && in_valid[idx])
      begin
        pick  = idx;
        found = 1'b1;
      end
    end

    state_d = state_q;
    cur_d   = cur_q;
    ev      = 6'h00;
    case (state_q)
      SCS_ST_FIXED:
        if (!fixed_q)
          state_d = SCS_ST_MASTER;
      SCS_ST_MASTER:
        if (fixed_q)
          state_d = SCS_ST_FIXED;
        else if (found)
        begin
          state_d = SCS_ST_SLAVE;
          cur_d   = pick;
          ev[`SCS_IRQ_SRC_CHG] = 1'b1;
        end
      SCS_ST_SLAVE:
        if (fixed_q)
          state_d = SCS_ST_FIXED;
        else if (in_valid[pref_q] && cur_q != pref_q)
        begin
          cur_d = pref_q;
          ev[`SCS_IRQ_SRC_CHG] = 1'b1;
        end
        else if (!in_valid[cur_q])
        begin
          ev[`SCS_IRQ_REF_LOST] = 1'b1;
          ev[`SCS_IRQ_SRC_CHG]  = 1'b1;
          // lost reference moves to the next valid input, else falls back to internal
          if (found)
            cur_d = pick;
          else
            state_d = SCS_ST_MASTER;
        end
      default:
        state_d = SCS_ST_MASTER;
    endcase

    // host rate request only applies while master
    rate_act_d = (state_q == SCS_ST_SLAVE) ? rate_act_q : rate_req_q;

    if (nominal >= `SCS_RATE_QUAD)
      chans_d = `SCS_CH_QUAD;
    else if (nominal >= `SCS_RATE_DOUBLE)
      chans_d = `SCS_CH_DOUBLE;
    else
      chans_d = `SCS_CH_SINGLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock and sync status

  logic [CW-1:0] ref_cnt, diff;

  always_comb
  begin
    ref_cnt   = (state_q == SCS_ST_SLAVE) ? in_cnt[cur_q] : int_cnt_lat_q;
    int_cnt_d = win_end ? '0 : int_cnt_q + CW'(acc_q[31] & ~msb_q);
    int_cnt_lat_d = win_end ? int_cnt_q : int_cnt_lat_q;
    lock_d    = lock_q;
    ev_in     = 4'h0;
    diff      = '0;
    // three states per input, sync means same rate as current clock
    for (int i = 0; i < NIN; i++)
    begin
      diff = (in_cnt[i] > ref_cnt) ? in_cnt[i] - ref_cnt
                                   : ref_cnt - in_cnt[i];
      if (!in_valid[i])
        lock_d[2*i +: 2] = SCS_LK_NONE;
      else if (diff <= `SCS_SYNC_TOL)
        lock_d[2*i +: 2] = SCS_LK_SYNC;
      else
        lock_d[2*i +: 2] = SCS_LK_LOCK;
      if (lock_d[2*i +: 2] != lock_q[2*i +: 2])
        ev_in[i] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register access and interrupt

  always_comb
  begin
    fixed_d    = wr_ctrl ? reg_wdata[`SCS_CTRL_FIXED] : fixed_q;
    pref_d     = wr_ctrl ? reg_wdata[`SCS_CTRL_PREF_LO +: 2] : pref_q;
    rate_req_d = wr_ctrl ? reg_wdata[`SCS_CTRL_RATE_LO +: 3] : rate_req_q;
    int_mask_d = (reg_wr && reg_addr == `SCS_A_INT_MASK) ? reg_wdata[5:0]
                                                         : int_mask_q;
    int_stat_d = int_stat_q;
    if (reg_wr && reg_addr == `SCS_A_INT_STAT)
      int_stat_d = int_stat_q & ~reg_wdata[5:0];
    // a new event wins over a same cycle clear
    int_stat_d = int_stat_d | ev | (6'(ev_in) << `SCS_IRQ_IN_LO);
    irq_d      = |(int_stat_d & int_mask_d);

    rdata_d = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `SCS_A_CTRL:
          rdata_d = {25'h0, rate_req_q, 1'b0, pref_q, fixed_q};
        `SCS_A_PITCH:    rdata_d = 32'(pitch_q);
        `SCS_A_STATUS:
          rdata_d = {1'b0, rate_act_q, 5'h00, madi_chans_q, 5'h00,
                     master_q, cur_q, lock_q};
        `SCS_A_INT_STAT: rdata_d = {26'h0, int_stat_q};
        `SCS_A_INT_MASK: rdata_d = {26'h0, int_mask_q};
        `SCS_A_TUNE:     rdata_d = tune_word_q;
        `SCS_A_EXT_CNT:  rdata_d = 32'(ref_cnt);
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      win_q         <= 8'h00;
      fixed_q       <= 1'b0;
      pref_q        <= 2'h0;
      rate_req_q    <= 3'h2;
      rate_act_q    <= 3'h2;
      pitch_q       <= 16'sh0000;
      int_stat_q    <= 6'h00;
      int_mask_q    <= 6'h00;
      reg_rdata_q   <= 32'h0000_0000;
      irq_q         <= 1'b0;
      state_q       <= SCS_ST_MASTER;
      cur_q         <= 2'h0;
      lock_q        <= 8'h00;
      int_cnt_q     <= '0;
      int_cnt_lat_q <= '0;
      acc_q         <= 32'h0000_0000;
      msb_q         <= 1'b0;
      tune_word_q   <= 32'h0000_0000;
      int_clk_q     <= 1'b0;
      master_q      <= 1'b1;
      cur_src_q     <= 2'h0;
      madi_chans_q  <= 7'h40;
    end
    else
    begin
      win_q         <= win_d;
      fixed_q       <= fixed_d;
      pref_q        <= pref_d;
      rate_req_q    <= rate_req_d;
      rate_act_q    <= rate_act_d;
      pitch_q       <= pitch_d;
      int_stat_q    <= int_stat_d;
      int_mask_q    <= int_mask_d;
      reg_rdata_q   <= rdata_d;
      irq_q         <= irq_d;
      state_q       <= state_d;
      cur_q         <= cur_d;
      lock_q        <= lock_d;
      int_cnt_q     <= int_cnt_d;
      int_cnt_lat_q <= int_cnt_lat_d;
      acc_q         <= acc_d;
      msb_q         <= acc_q[31];
      tune_word_q   <= tw_d;
      int_clk_q     <= acc_q[31];
      master_q      <= (state_d != SCS_ST_SLAVE);
      cur_src_q     <= cur_d;
      madi_chans_q  <= chans_d;
    end
  end

endmodule // scs_selector

`default_nettype wire

// *** test/scs_sel_properties.sv ***
// concurrent checks on the clock selector ports
`timescale 1ns/1ps
`default_nettype none

module scs_sel_properties
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic        master_q,
  input wire logic [1:0]  cur_src_q,
  input wire logic [31:0] tune_word_q,
  input wire logic [6:0]  madi_chans_q
);
  logic fix_q;
  logic fix_d;

  // shadow of the fixed-mode bit, as last written by software
  always_comb
  begin
    fix_d = fix_q;
    if (reg_wr && reg_addr == 8'h00)
      fix_d = reg_wdata[0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      fix_q <= 1'b0;
    else
      fix_q <= fix_d;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data not idle");
  a_unmapped_rd: assert property ($past(reg_rd) && $past(reg_addr) > 8'h1C
    |-> reg_rdata_q == 32'h0)
    else $error("unmapped read not zero");
  a_pstep_rd: assert property ($past(reg_rd) && $past(reg_addr) == 8'h08
    |-> reg_rdata_q == 32'h0)
    else $error("step register read not zero");
  a_stat_master: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0C
    |-> reg_rdata_q[10] == $past(master_q))
    else $error("status master bit differs");
  a_stat_src: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0C
    && !$past(master_q) |-> reg_rdata_q[9:8] == $past(cur_src_q))
    else $error("status source differs");
  a_stat_chans: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0C
    |-> reg_rdata_q[22:16] == $past(madi_chans_q))
    else $error("status channel count differs");
  a_tune_read: assert property ($past(reg_rd) && $past(reg_addr) == 8'h18
    |-> reg_rdata_q == $past(tune_word_q))
    else $error("tuning word read differs");
  a_chans_legal: assert property (madi_chans_q == 7'h40
    || madi_chans_q == 7'h20 || madi_chans_q == 7'h10)
    else $error("channel count illegal");
  a_fixed_enter: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0]
    |-> ##[1:3] master_q)
    else $error("fixed mode not entered");
  a_fixed_hold: assert property (fix_q [*4] |-> master_q)
    else $error("fixed mode left internal clock");
endmodule // scs_sel_properties

bind scs_selector scs_sel_properties scs_sel_properties_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .master_q(master_q), .cur_src_q(cur_src_q),
  .tune_word_q(tune_word_q), .madi_chans_q(madi_chans_q));

`default_nettype wire

// *** test/scs_ref_source.sv ***
// reference clock gear feeding the four sync inputs
`timescale 1ns/1ps
`default_nettype none

module scs_ref_source
#(
  parameter real HALF_NS = 400.0
)
(
  input  wire logic [3:0] en,
  output logic      [3:0] pin
);
  logic tgl = 1'b0;

  // free running word clock, phase unrelated to the system clock
  initial
  begin
    #137;
    forever
      #(HALF_NS) tgl = ~tgl;
  end

  // an unplugged line sits at its terminated low level
  assign pin = en & {4{tgl}};
endmodule // scs_ref_source

`default_nettype wire

// *** test/scs_selector_tb_top.sv ***
// self-checking bench for the sample clock source selector
`timescale 1ns/1ps
`default_nettype none
`include "scs_defines.svh"

module scs_selector_tb_top;
  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [3:0]  en        = 4'h0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [3:0]  ref_pin;
  logic [31:0] reg_rdata_q;
  logic        irq_q;
  logic        master_q;
  logic [1:0]  cur_src_q;
  logic [31:0] tune_word_q;
  logic        int_clk_q;
  logic [6:0]  madi_chans_q;
  logic [31:0] d;
  int          err_total = 0;
  int          compares  = 0;
  int          pitch     = 0;
  int          rate      = 2;
  int          n_edge    = 0;
  logic        clk_prev  = 1'b0;

  always #50 ref_clk = ~ref_clk;

  scs_selector scs_selector_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .ref_pin(ref_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .irq_q(irq_q), .master_q(master_q), .cur_src_q(cur_src_q),
    .tune_word_q(tune_word_q), .int_clk_q(int_clk_q),
    .madi_chans_q(madi_chans_q));
  scs_ref_source scs_ref_source_inst (.en(en), .pin(ref_pin));

  //////////////////////////////////////////////////////////////////////////
  function automatic int nom(int r);
    int t[7] = '{32000, 44100, 48000, 88200, 96000, 176400, 192000};
    return t[r];
  endfunction
  function automatic int clampp(int p, int r);
    int l;
    l = nom(r) / 20;
    return p > l ? l : (p < -l ? -l : p);
  endfunction
  function automatic logic [31:0] tw(int r, int p);
    longint f;
    f = nom(r) + p;
    return 32'((f * `SCS_TW_MUL) >> 8);
  endfunction

  task automatic chk(logic [31:0] seen, logic [31:0] exp, string m);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic wait_sel(logic m, logic [1:0] s);
    int n;
    n = 0;
    #1;
    while (n < 2000 && !(master_q === m && (m || cur_src_q === s)))
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(32'(master_q), 32'(m), "master");
    if (!m)
      chk(32'(cur_src_q), 32'(s), "source");
  endtask
  task automatic stat_chk(int ar);
    rd(`SCS_A_STATUS);
    for (int i = 0; i < 4; i++)
      chk(32'(d[2*i +: 2] != 2'b00), 32'(en[i]), "lock");
    if (!master_q)
      chk(32'(d[2*cur_src_q +: 2]), 32'h2, "sync");
    chk(32'(d[30:28]), ar, "rate");
  endtask
  task automatic step(int b);
    int l;
    l = nom(rate);
    case (b)
      0: pitch += 1;
      1: pitch -= 1;
      2: pitch += 50;
      3: pitch -= 50;
      4: pitch = 0;
      5: pitch = l / 1000;
      6: pitch = -(l / 1000);
      7: pitch = l / 25;
      default: pitch = -(l / 25);
    endcase
    pitch = clampp(pitch, rate);
    wr(`SCS_A_PSTEP, 32'h1 << b);
    rd(`SCS_A_PITCH);
    chk(d, pitch, "pitch");
    repeat (3) @(posedge ref_clk);
    #1 chk(tune_word_q, tw(rate, pitch), "tune");
  endtask
  task automatic close_out();
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, some twenty times the expected run
  initial
  begin
    #8ms;
    err_total++;
    close_out();
  end

  initial
  begin
    void'($urandom(32'hA51C));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk(32'(master_q), 32'h1, "reset master");
    chk(32'(madi_chans_q), 32'h40, "reset chans");
    rd(`SCS_A_CTRL);
    chk(d, `SCS_CTRL_RST, "ctrl reset");
    chk(tune_word_q, tw(2, 0), "reset tune");
    repeat (30) step($urandom_range(8));
    // rate first, then pitch: a later rate change would only re-clamp
    for (int r = 0; r < 7; r++)
    begin
      wr(`SCS_A_CTRL, r << 4);
      wr(`SCS_A_PITCH, (r % 2) ? -30000 : 30000);
      rate = r;
      pitch = clampp((r % 2) ? -30000 : 30000, r);
      rd(`SCS_A_PITCH);
      chk(d, pitch, "clamp");
      repeat (3) @(posedge ref_clk);
      #1 chk(tune_word_q, tw(r, pitch), "rate tune");
      chk(32'(madi_chans_q), r > 4 ? 16 : (r > 2 ? 32 : 64), "chans");
    end
    wr(`SCS_A_CTRL, 32'h20);
    rate = 2;
    step(4);
    step(2);
    wr(`SCS_A_INT_MASK, 32'h3);
    wr(`SCS_A_INT_STAT, 32'h3F);
    @(posedge ref_clk) en <= 4'h1;
    wait_sel(1'b0, 2'd0);
    repeat (600) @(posedge ref_clk);
    #1 chk(32'(irq_q), 32'h1, "irq source");
    chk(tune_word_q, tw(2, 0), "slave tune");
    wr(`SCS_A_INT_STAT, 32'h3F);
    repeat (3) @(posedge ref_clk);
    #1 chk(32'(irq_q), 32'h0, "irq clear");
    wr(`SCS_A_CTRL, 32'h00);
    repeat (4) @(posedge ref_clk);
    stat_chk(2);
    @(posedge ref_clk) en <= 4'h7;
    wr(`SCS_A_CTRL, 32'h04);
    wait_sel(1'b0, 2'd2);
    wr(`SCS_A_INT_STAT, 32'h3F);
    @(posedge ref_clk) en <= 4'h2;
    wait_sel(1'b0, 2'd1);
    rd(`SCS_A_INT_STAT);
    chk(32'(d[1]), 32'h1, "ref lost");
    wr(`SCS_A_INT_MASK, 32'h0);
    wr(`SCS_A_INT_STAT, 32'h3F);
    @(posedge ref_clk) en <= 4'h0;
    wait_sel(1'b1, 2'd0);
    repeat (600) @(posedge ref_clk);
    stat_chk(0);
    chk(32'(irq_q), 32'h0, "irq masked");
    chk(tune_word_q, tw(0, pitch), "master tune");
    wr(`SCS_A_INT_MASK, 32'h2);
    repeat (3) @(posedge ref_clk);
    #1 chk(32'(irq_q), 32'h1, "irq unmask");
    wr(`SCS_A_INT_STAT, 32'h2);
    repeat (3) @(posedge ref_clk);
    #1 chk(32'(irq_q), 32'h0, "irq w1c");
    @(posedge ref_clk) en <= 4'hF;
    wr(`SCS_A_CTRL, 32'h06);
    wait_sel(1'b0, 2'd3);
    wr(`SCS_A_CTRL, 32'h07);
    repeat (3) @(posedge ref_clk);
    #1 chk(32'(master_q), 32'h1, "fixed");
    // about 32 kHz over 100 us: three or four rising edges
    for (int i = 0; i < 1000; i++)
    begin
      @(posedge ref_clk);
      #1;
      if (int_clk_q && !clk_prev)
        n_edge++;
      clk_prev = int_clk_q;
    end
    chk(32'(master_q), 32'h1, "fixed hold");
    chk(32'(n_edge >= 3 && n_edge <= 4), 32'h1, "int clock");
    rd(8'h40);
    chk(d, 32'h0, "unmapped");
    rd(`SCS_A_PSTEP);
    chk(d, 32'h0, "step read");
    close_out();
  end
endmodule // scs_selector_tb_top

`default_nettype wire
